//--- src/sfs_defs.svh
`ifndef SFS_DEFS_SVH
`define SFS_DEFS_SVH

// clock rate
`define SFS_CLK_MHZ       100
`define SFS_CLK_NS        10

// serial word
`define SFS_WORD_BITS     8
`define SFS_CNT_W         4

// command address field, d6:d4
`define SFS_ADDR_HI       6
`define SFS_ADDR_LO       4
`define SFS_WD_BIT        7
`define SFS_A_STATUS      3'h0
`define SFS_A_OUTCTL      3'h1
`define SFS_A_TRIP        3'h2
`define SFS_A_QUAL        3'h3
`define SFS_A_SUPPLY      3'h6

// data fields
`define SFS_OUT_SPI_BIT   0
`define SFS_HIGH_SEL_BIT  3
`define SFS_LOW_SEL_HI    2
`define SFS_QUAL_SEL_HI   1
`define SFS_UV_OFF_BIT    1

// fault byte
`define SFS_F_LOW_OC      0
`define SFS_F_HIGH_OC     1
`define SFS_F_UV          2
`define SFS_F_GND         3
`define SFS_F_OUT_ON      7

// low trip qualify time choices, in microseconds
`define SFS_QUAL_US0      150
`define SFS_QUAL_US1      10
`define SFS_QUAL_US2      1000
`define SFS_QUAL_US3      1200

// host serial clock half period
`define SFS_SCLK_HALF_NS  80

// host apb map
`define SFS_REG_TXDATA    8'h00
`define SFS_REG_RXDATA    8'h04
`define SFS_REG_IRQ_STAT  8'h08
`define SFS_REG_IRQ_MASK  8'h0C
`define SFS_REG_STATUS    8'h10
`define SFS_IRQ_DONE      0
`define SFS_ST_BUSY       0

`endif

//--- src/sfs_pkg.sv
package sfs_pkg;
  typedef enum logic [1:0] {
    SFS_IDLE  = 2'b00,
    SFS_LEAD  = 2'b01,
    SFS_SHIFT = 2'b10,
    SFS_TRAIL = 2'b11
  } sfs_host_state_e;
  typedef logic [7:0] sfs_byte_t;
endpackage

//--- src/sfs_link_if.sv
`timescale 1ns/1ps
interface sfs_link_if;
  logic sclk;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  modport dev (
    input  sclk,
    input  cs_n,
    input  si,
    output so,
    output so_oe
  );
  modport host (
    output sclk,
    output cs_n,
    output si,
    input  so,
    input  so_oe
  );
endinterface

//--- src/sfs_device.sv
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "sfs_defs.svh"
module sfs_device
  import sfs_pkg::*;
#(
  parameter int QUAL_US0 = `SFS_QUAL_US0,
  parameter int QUAL_US1 = `SFS_QUAL_US1,
  parameter int QUAL_US2 = `SFS_QUAL_US2,
  parameter int QUAL_US3 = `SFS_QUAL_US3
) (
  input  wire logic       REF_CLK,
  input  wire logic       SRST,
  sfs_link_if.dev         LINK,
  input  wire logic [7:0] LOW_TRIP_HIT,
  input  wire logic [1:0] HIGH_TRIP_HIT,
  input  wire logic       SUPPLY_UV,
  input  wire logic       SUPPLY_POR,
  input  wire logic       GND_LOSS,
  input  wire logic       IN_PIN,
  output logic            OUT_ON,
  output logic            FAULT_FLAG_PIN_N
);

  localparam int TW = 24;
  localparam logic [TW-1:0] QUAL_CYC0 = TW'(QUAL_US0 * `SFS_CLK_MHZ);
  localparam logic [TW-1:0] QUAL_CYC1 = TW'(QUAL_US1 * `SFS_CLK_MHZ);
  localparam logic [TW-1:0] QUAL_CYC2 = TW'(QUAL_US2 * `SFS_CLK_MHZ);
  localparam logic [TW-1:0] QUAL_CYC3 = TW'(QUAL_US3 * `SFS_CLK_MHZ);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [16:0] meta_ff;
  logic [16:0] sync_ff;
  logic        sclk_d_ff;
  logic [7:0]  low_hit;
  logic [1:0]  high_hit;
  logic        uv;
  logic        por;
  logic        gnd;
  logic        in_pin;
  logic        sclk_s;
  logic        cs_n_s;
  logic        si_s;

  always_ff @(posedge REF_CLK) begin
    meta_ff   <= {LINK.sclk, LINK.cs_n, LINK.si, GND_LOSS, SUPPLY_POR, SUPPLY_UV,
                  IN_PIN, HIGH_TRIP_HIT, LOW_TRIP_HIT};
    sync_ff   <= meta_ff;
    sclk_d_ff <= sync_ff[16];
  end

  assign low_hit  = sync_ff[7:0];
  assign high_hit = sync_ff[9:8];
  assign in_pin   = sync_ff[10];
  assign uv       = sync_ff[11];
  assign por      = sync_ff[12];
  assign gnd      = sync_ff[13];
  assign si_s     = sync_ff[14];
  assign cs_n_s   = sync_ff[15];
  assign sclk_s   = sync_ff[16];

  // ----------------------------------------------------------------
  // serial link
  // ----------------------------------------------------------------
  logic       cs_n_d_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic [`SFS_CNT_W-1:0] bits_ff;
  logic       sel_fault_ff;
  logic       so_ff;
  logic       so_oe_ff;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       word_ok;
  sfs_byte_t  reply_now;

  always_comb reply_now = reply(sel_fault_ff);

  assign sclk_rise = !cs_n_s && sclk_s && !sclk_d_ff;
  assign sclk_fall = !cs_n_s && !sclk_s && sclk_d_ff;
  assign cs_fall   = cs_n_d_ff && !cs_n_s;
  assign cs_rise   = !cs_n_d_ff && cs_n_s;
  assign word_ok   = cs_rise && (bits_ff == `SFS_CNT_W'(`SFS_WORD_BITS));

  always_ff @(posedge REF_CLK) begin
    if (SRST) cs_n_d_ff <= 1'b1;
    else      cs_n_d_ff <= cs_n_s;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      rx_ff   <= 8'h00;
      bits_ff <= '0;
    end else if (cs_fall) begin
      bits_ff <= '0;
    end else if (sclk_fall) begin
      rx_ff <= {rx_ff[6:0], si_s};
      if (bits_ff == `SFS_CNT_W'(`SFS_WORD_BITS))
        bits_ff <= `SFS_CNT_W'(1);
      else
        bits_ff <= bits_ff + `SFS_CNT_W'(1);
    end
  end

  // shift out on rise; msb first, input follows
  always_ff @(posedge REF_CLK) begin
    if (SRST) tx_ff <= 8'h00;
    else if (cs_fall) tx_ff <= reply_now;
    else if (sclk_rise) tx_ff <= {tx_ff[6:0], rx_ff[0]};
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      so_ff    <= 1'b0;
      so_oe_ff <= 1'b0;
    end else begin
      so_oe_ff <= !cs_n_s;
      // msb stands from select to the second rise, so the first fall sees it
      if (cs_fall) so_ff <= reply_now[7];
      else if (sclk_rise) so_ff <= tx_ff[7];
    end
  end

  assign LINK.so    = so_ff;
  assign LINK.so_oe = so_oe_ff;

  // ----------------------------------------------------------------
  // configuration written at select release
  // ----------------------------------------------------------------
  logic       out_spi_ff;
  logic [2:0] low_sel_ff;
  logic       high_sel_ff;
  logic [1:0] qual_sel_ff;
  logic       uv_off_ff;
  logic [2:0] addr;

  assign addr = rx_ff[`SFS_ADDR_HI:`SFS_ADDR_LO];

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      out_spi_ff   <= 1'b0;
      low_sel_ff   <= 3'h0;
      high_sel_ff  <= 1'b0;
      qual_sel_ff  <= 2'h0;
      uv_off_ff    <= 1'b0;
      sel_fault_ff <= 1'b1;
    end else if (word_ok) begin
      unique case (addr)
        `SFS_A_STATUS: sel_fault_ff <= (rx_ff[2:0] == `SFS_A_STATUS);
        `SFS_A_OUTCTL: out_spi_ff <= rx_ff[`SFS_OUT_SPI_BIT];
        `SFS_A_TRIP: begin
          high_sel_ff <= rx_ff[`SFS_HIGH_SEL_BIT];
          low_sel_ff  <= rx_ff[`SFS_LOW_SEL_HI:0];
        end
        `SFS_A_QUAL: qual_sel_ff <= rx_ff[`SFS_QUAL_SEL_HI:0];
        `SFS_A_SUPPLY: begin
          if (rx_ff[`SFS_WD_BIT]) uv_off_ff <= rx_ff[`SFS_UV_OFF_BIT];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // protection
  // ----------------------------------------------------------------
  logic          cmd;
  logic          cmd_d_ff;
  logic          low_now;
  logic          high_now;
  logic [TW-1:0] qual_cnt_ff;
  logic [TW-1:0] qual_lim;
  logic          oc_low_ff;
  logic          oc_high_ff;
  logic          oc_off_seen_ff;
  logic          uv_latch_ff;
  logic          uv_live;
  logic          drive;

  assign cmd = in_pin || out_spi_ff;

  // one of eight low, one of two high
  assign low_now  = low_hit[low_sel_ff];
  assign high_now = high_hit[high_sel_ff];

  always_comb begin
    unique case (qual_sel_ff)
      2'h0: qual_lim = QUAL_CYC0;
      2'h1: qual_lim = QUAL_CYC1;
      2'h2: qual_lim = QUAL_CYC2;
      2'h3: qual_lim = QUAL_CYC3;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) cmd_d_ff <= 1'b0;
    else      cmd_d_ff <= cmd;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST || !low_now || !drive) qual_cnt_ff <= '0;
    else if (qual_cnt_ff != qual_lim) qual_cnt_ff <= qual_cnt_ff + TW'(1);
  end

  // off seen while latched, then on releases
  always_ff @(posedge REF_CLK) begin
    if (SRST) oc_off_seen_ff <= 1'b0;
    else if (!(oc_low_ff || oc_high_ff)) oc_off_seen_ff <= 1'b0;
    else if (!cmd) oc_off_seen_ff <= 1'b1;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) oc_low_ff <= 1'b0;
    else if (drive && low_now && qual_cnt_ff == qual_lim) oc_low_ff <= 1'b1;
    else if (oc_off_seen_ff && cmd) oc_low_ff <= 1'b0;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) oc_high_ff <= 1'b0;
    else if (drive && high_now) oc_high_ff <= 1'b1;
    else if (oc_off_seen_ff && cmd) oc_high_ff <= 1'b0;
  end

  assign uv_live = (uv || por) && !uv_off_ff;

  // recovery with command on holds until off
  always_ff @(posedge REF_CLK) begin
    if (SRST) uv_latch_ff <= 1'b0;
    else if (uv_live && cmd) uv_latch_ff <= 1'b1;
    else if (!cmd) uv_latch_ff <= 1'b0;
  end

  assign drive = cmd && !oc_low_ff && !oc_high_ff && !uv_live && !uv_latch_ff
                 && !por && !gnd;

  always_ff @(posedge REF_CLK) begin
    if (SRST) OUT_ON <= 1'b0;
    else      OUT_ON <= drive && !high_now;
  end

  // pin high below por level; low on undervolt
  always_ff @(posedge REF_CLK) begin
    if (SRST)     FAULT_FLAG_PIN_N <= 1'b1;
    else if (por) FAULT_FLAG_PIN_N <= 1'b1;
    else          FAULT_FLAG_PIN_N <= !(oc_low_ff || oc_high_ff || uv_live || uv_latch_ff);
  end

  // ----------------------------------------------------------------
  // fault register
  // ----------------------------------------------------------------
  logic [3:0] fault_ff;
  logic [3:0] fault_set;
  logic       fault_clr;

  assign fault_set = {gnd, uv_live, oc_high_ff, oc_low_ff};
  // cleared by the transfer that returned it
  assign fault_clr = word_ok && sel_fault_ff;

  // set wins over clear
  always_ff @(posedge REF_CLK) begin
    if (SRST)           fault_ff <= 4'h0;
    else if (fault_clr) fault_ff <= fault_set;
    else                fault_ff <= fault_ff | fault_set;
  end

  // reply byte selected by status command
  function automatic sfs_byte_t reply(input logic fsel);
    sfs_byte_t r;
    r = 8'h00;
    if (fsel) begin
      r[`SFS_F_LOW_OC]  = fault_ff[0];
      r[`SFS_F_HIGH_OC] = fault_ff[1];
      r[`SFS_F_UV]      = fault_ff[2];
      r[`SFS_F_GND]     = fault_ff[3];
      r[`SFS_F_OUT_ON]  = OUT_ON;
    end else begin
      r = {1'b0, uv_off_ff, qual_sel_ff, high_sel_ff, low_sel_ff};
    end
    return r;
  endfunction

endmodule

//--- src/sfs_host.sv
`timescale 1ns/1ps
`include "sfs_defs.svh"
module sfs_host
  import sfs_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  sfs_link_if.host         LINK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ
);

  localparam int HALF = (`SFS_SCLK_HALF_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS;

  // ----------------------------------------------------------------
  // apb slave, one wait cycle
  // ----------------------------------------------------------------
  sfs_host_state_e st_ff;
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  logic       done_ff;
  logic       mask_ff;
  logic       start;
  logic       done_ev;
  logic       acc;
  logic       wr;

  assign acc   = PSEL && PENABLE && PREADY;
  assign wr    = acc && PWRITE;
  assign start = wr && PADDR == `SFS_REG_TXDATA && st_ff == SFS_IDLE;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      if (PSEL && PENABLE && !PREADY && !PWRITE) begin
        unique case (PADDR)
          `SFS_REG_RXDATA:   PRDATA <= {24'h00_0000, rx_ff};
          `SFS_REG_IRQ_STAT: PRDATA <= {31'h0, done_ff};
          `SFS_REG_IRQ_MASK: PRDATA <= {31'h0, mask_ff};
          `SFS_REG_STATUS:   PRDATA <= {31'h0, st_ff != SFS_IDLE};
          `SFS_REG_TXDATA:   PRDATA <= {24'h00_0000, tx_ff};
          default:           PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) mask_ff <= 1'b0;
    else if (wr && PADDR == `SFS_REG_IRQ_MASK) mask_ff <= PWDATA[`SFS_IRQ_DONE];
  end

  // sticky done, write one clears, set wins
  always_ff @(posedge REF_CLK) begin
    if (SRST) done_ff <= 1'b0;
    else if (done_ev) done_ff <= 1'b1;
    else if (wr && PADDR == `SFS_REG_IRQ_STAT && PWDATA[`SFS_IRQ_DONE]) done_ff <= 1'b0;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) IRQ <= 1'b0;
    else      IRQ <= (done_ff || done_ev) && mask_ff;
  end

  // ----------------------------------------------------------------
  // serial master
  // ----------------------------------------------------------------
  logic [7:0] div_ff;
  logic [3:0] bit_ff;
  logic       so_meta_ff;
  logic       so_s_ff;
  logic       sclk_ff;
  logic       cs_n_ff;
  logic       si_ff;
  logic       tick;

  assign tick    = div_ff == 8'(HALF - 1);
  assign done_ev = st_ff == SFS_TRAIL && tick;

  always_ff @(posedge REF_CLK) begin
    so_meta_ff <= LINK.so;
    so_s_ff    <= so_meta_ff;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST || st_ff == SFS_IDLE || tick) div_ff <= 8'h00;
    else div_ff <= div_ff + 8'h01;
  end

  // select moves only with clock low; idle low
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      st_ff   <= SFS_IDLE;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      si_ff   <= 1'b0;
      tx_ff   <= 8'h00;
      rx_ff   <= 8'h00;
      bit_ff  <= 4'h0;
    end else begin
      unique case (st_ff)
        SFS_IDLE: if (start) begin
          tx_ff   <= PWDATA[7:0];
          si_ff   <= PWDATA[7];
          cs_n_ff <= 1'b0;
          bit_ff  <= 4'h0;
          st_ff   <= SFS_LEAD;
        end
        SFS_LEAD: if (tick) begin
          sclk_ff <= 1'b1;
          st_ff   <= SFS_SHIFT;
        end
        SFS_SHIFT: if (tick) begin
          sclk_ff <= !sclk_ff;
          if (sclk_ff) begin
            rx_ff  <= {rx_ff[6:0], so_s_ff};
            tx_ff  <= {tx_ff[6:0], 1'b0};
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == 4'(`SFS_WORD_BITS - 1)) st_ff <= SFS_TRAIL;
          end else begin
            si_ff <= tx_ff[7];
          end
        end
        SFS_TRAIL: if (tick) begin
          cs_n_ff <= 1'b1;
          st_ff   <= SFS_IDLE;
        end
      endcase
    end
  end

  assign LINK.sclk = sclk_ff;
  assign LINK.cs_n = cs_n_ff;
  assign LINK.si   = si_ff;

endmodule

//--- sim/sfs_link_chk.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// link wire checks
// ------------------------------------------------------------
module sfs_link_chk (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  property p_idle_oe; cs_n [*6] |-> !so_oe; endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("so driven while deselected");
  property p_sel_oe; !cs_n [*6] |-> so_oe; endproperty
  a_sel_oe: assert property (p_sel_oe) else $error("so not driven while selected");
  property p_cs_clk; $changed(cs_n) |-> !sclk && !$past(sclk); endproperty
  a_cs_clk: assert property (p_cs_clk) else $error("select moved with clock high");
  property p_idle_clk; cs_n |-> !sclk; endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock high while idle");
  property p_so_hold; $fell(sclk) |-> $stable(so) [*4]; endproperty
  a_so_hold: assert property (p_so_hold) else $error("so moved near clock fall");
  property p_si_hold; $fell(sclk) |=> $stable(si) [*3]; endproperty
  a_si_hold: assert property (p_si_hold) else $error("si moved after clock fall");
  property p_half; $rose(sclk) |-> sclk [*8] ##1 !sclk; endproperty
  a_half: assert property (p_half) else $error("clock high phase not 8 cycles");
  property p_lead; $fell(cs_n) |-> !sclk [*8]; endproperty
  a_lead: assert property (p_lead) else $error("clock rose too soon after select");
endmodule

//--- sim/switch_fault_supervisor_bench.sv
`timescale 1ns/1ps
`include "sfs_defs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module switch_fault_supervisor_bench
  import sfs_pkg::*;
;
  typedef struct {
    logic       uv, por, gnd;
    logic [1:0] hi;
    logic       out, pin, hold;
    sfs_byte_t  flt;
  } sfs_row_s;
  // ------------------------------------------------------------
  // stimulus and checks
  // ------------------------------------------------------------
  logic        ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, low_hit = 8'h00;
  logic [31:0] pwdata = 32'h0, r;
  logic [1:0]  high_hit = 2'b00;
  logic        sup_uv = 1'b0, sup_por = 1'b0, gnd_loss = 1'b0, in_pin = 1'b0;
  logic        irq_on = 1'b0, e;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, out_on, flag_n;
  int          failures = 0, compares = 0, nfall = 0;
  sfs_byte_t   si_cap, so_cap, rx;
  sfs_row_s    rows [4] = '{'{0, 0, 0, 2'b01, 0, 0, 1, 8'h02}, '{1, 0, 0, 2'b00, 0, 0, 1, 8'h04},
                            '{0, 0, 1, 2'b00, 0, 1, 0, 8'h08}, '{1, 1, 0, 2'b00, 0, 1, 1, 8'h04}};
  always #5 ref_clk = ~ref_clk;
  sfs_link_if sfs_link_if_inst ();
  sfs_device #(.QUAL_US0(2), .QUAL_US1(1), .QUAL_US2(3), .QUAL_US3(4)) sfs_device_inst (
    .REF_CLK(ref_clk), .SRST(srst), .LINK(sfs_link_if_inst), .LOW_TRIP_HIT(low_hit),
    .HIGH_TRIP_HIT(high_hit), .SUPPLY_UV(sup_uv), .SUPPLY_POR(sup_por), .GND_LOSS(gnd_loss),
    .IN_PIN(in_pin), .OUT_ON(out_on), .FAULT_FLAG_PIN_N(flag_n));
  sfs_host sfs_host_inst (
    .REF_CLK(ref_clk), .SRST(srst), .LINK(sfs_link_if_inst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq));
  sfs_link_chk sfs_link_chk_inst (
    .REF_CLK(ref_clk), .SRST(srst), .sclk(sfs_link_if_inst.sclk), .cs_n(sfs_link_if_inst.cs_n),
    .si(sfs_link_if_inst.si), .so(sfs_link_if_inst.so), .so_oe(sfs_link_if_inst.so_oe));
  // wire view of each frame, taken where the device samples
  always @(negedge sfs_link_if_inst.sclk) if (sfs_link_if_inst.cs_n === 1'b0) begin
    si_cap = {si_cap[6:0], sfs_link_if_inst.si};
    so_cap = {so_cap[6:0], sfs_link_if_inst.so};
    nfall++;
  end
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin failures++; stop_test(); end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        err;
    apb(1'b1, a, d, q, err);
  endtask
  task automatic xfer(input sfs_byte_t tx, output sfs_byte_t got);
    logic [31:0] q;
    logic        err;
    int          n;
    nfall = 0;
    n = 0;
    wr(`SFS_REG_TXDATA, {24'h0, tx});
    do begin apb(1'b0, `SFS_REG_IRQ_STAT, 32'h0, q, err); n++; end
      while (q[`SFS_IRQ_DONE] !== 1'b1 && n < 100);
    if (n >= 100) begin failures++; stop_test(); end
    `CHK("irq", irq_on, irq)
    wr(`SFS_REG_IRQ_STAT, 32'h1);
    apb(1'b0, `SFS_REG_RXDATA, 32'h0, q, err);
    got = q[7:0];
    `CHK("irq clear", 1'b0, irq)
    `CHK("falls", 8, nfall)
    `CHK("si wire", tx, si_cap)
    `CHK("so wire", got, so_cap)
  endtask
  task automatic settle();
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic pins(input logic o, input logic p);
    `CHK("out", o, out_on)
    `CHK("flag", p, flag_n)
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    pins(1'b0, 1'b1);
    wr(`SFS_REG_IRQ_MASK, 32'h1);
    irq_on = 1'b1;
    xfer(8'h11, rx);
    `CHK("fault", 8'h00, rx)
    settle();
    pins(1'b1, 1'b1);
    foreach (rows[i]) begin
      sup_uv <= rows[i].uv;
      sup_por <= rows[i].por;
      gnd_loss <= rows[i].gnd;
      high_hit <= rows[i].hi;
      settle();
      pins(rows[i].out, rows[i].pin);
      xfer(8'h00, rx);
      `CHK("fault", rows[i].flt, rx)
      {sup_uv, sup_por, gnd_loss} <= 3'b000;
      high_hit <= 2'b00;
      settle();
      if (rows[i].hold) begin
        xfer(8'h11, rx);
        settle();
        pins(1'b0, 1'b0);
      end
      xfer(8'h10, rx);
      xfer(8'h11, rx);
      settle();
      pins(1'b1, 1'b1);
      xfer(8'h00, rx);
      // an overcurrent latch still holds at the transfer that releases it
      `CHK("cleared", 8'h80 | (rows[i].flt & 8'h03), rx)
      $display("row %0d done", i);
    end
    for (int s = 0; s < 8; s++) begin
      xfer({4'h2, s[0], s[2:0]}, rx);
      low_hit <= ~(8'h01 << s);
      high_hit <= s[0] ? 2'b01 : 2'b10;
      repeat (300) @(posedge ref_clk);
      pins(1'b1, 1'b1);
      // levels off before the next selection lands
      low_hit <= 8'h00;
      high_hit <= 2'b00;
    end
    high_hit <= 2'b00;
    low_hit <= 8'h80;
    repeat (150) @(posedge ref_clk);
    low_hit <= 8'h00;
    settle();
    low_hit <= 8'h80;
    repeat (150) @(posedge ref_clk);
    pins(1'b1, 1'b1);
    repeat (100) @(posedge ref_clk);
    pins(1'b0, 1'b0);
    low_hit <= 8'h00;
    xfer(8'h00, rx);
    `CHK("low fault", 8'h01, rx)
    xfer(8'h10, rx);
    xfer(8'h11, rx);
    settle();
    pins(1'b1, 1'b1);
    $display("trip levels done");
    xfer(8'hE2, rx);
    sup_uv <= 1'b1;
    settle();
    pins(1'b1, 1'b1);
    xfer(8'h00, rx);
    `CHK("uv off fault", 8'h80, rx)
    sup_por <= 1'b1;
    settle();
    pins(1'b0, 1'b1);
    {sup_uv, sup_por} <= 2'b00;
    settle();
    pins(1'b1, 1'b1);
    xfer(8'h10, rx);
    settle();
    pins(1'b0, 1'b1);
    in_pin <= 1'b1;
    settle();
    pins(1'b1, 1'b1);
    wr(`SFS_REG_IRQ_MASK, 32'h0);
    irq_on = 1'b0;
    xfer(8'h00, rx);
    apb(1'b0, 8'h20, 32'h0, r, e);
    `CHK("slverr", 1'b1, e)
    $display("supply and host done");
    stop_test();
  end
endmodule
